//--- hw/eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// ==========================================
// Array geometry
`define ARRAY_DEPTH        128
`define ADDR_BITS          7
`define PAGE_BITS          3
// ==========================================
// Status register fields
`define STAT_BUSY_BIT      0
`define STAT_WEL_BIT       1
`define STAT_BP_LO_BIT     2
`define STAT_BP_HI_BIT     3
// Factory value of the block-protect pair
`define BP_FACTORY         2'h0
// ==========================================
// Protected range lower bounds
`define BP1_BASE           7'h60
`define BP2_BASE           7'h40
`define BP3_BASE           7'h00
// ==========================================
// Self-timed write cycle: time in ns and clocks at 20 MHz
`define WRITE_TIME_NS      5000000
`define CLK_PERIOD_NS      50
`define WRITE_CYCLES       (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- hw/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

	// Decoded instruction (low three bits of the opcode)
	typedef enum logic [2:0]
	{
		op_status_write  = 3'h1,
		op_array_write   = 3'h2,
		op_array_read    = 3'h3,
		op_clear_latch   = 3'h4,
		op_status_read   = 3'h5,
		op_set_latch     = 3'h6,
		op_invalid       = 3'h0
	} opcode_t;

	// Serial front end phase
	typedef enum logic [2:0]
	{
		ph_opcode  = 3'h0,
		ph_address = 3'h1,
		ph_data_in = 3'h2,
		ph_out     = 3'h3,
		ph_idle    = 3'h4
	} phase_t;

endpackage
`default_nettype wire

//--- hw/eeprom_array.sv
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_params.svh"

// Byte array with registered read data
module eeprom_array
(
	// Clock
	input  wire logic       clk,
	// Write port
	input  wire logic       wr_en,
	input  wire logic [6:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// Read port
	input  wire logic [6:0] rd_addr,
	output logic      [7:0] rd_data
);

	// Storage, survives reset as a non-volatile array would
	logic [7:0] mem [0:`ARRAY_DEPTH-1];

	// ==========================================
	// Write and registered read
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

//--- hw/spi_eeprom_status_protect.sv
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_params.svh"

module spi_eeprom_status_protect
#(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Serial pins
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	output logic      so,
	output logic      so_oe,
	// Protection and suspend pins
	input  wire logic wp_n,
	input  wire logic hold_n,
	// State visible outside
	output logic      busy,
	output logic      standby
);

	// ==========================================
	// Pin synchronisers
	logic [4:0] sync1_q;   // First stage, read only by second
	logic [4:0] sync2_q;   // Second stage
	logic       sck_prev_q;// Clock history for edge finding
	logic       cs_prev_q; // Select history for edge finding

	// Two flops on every pin input
	always_ff @(posedge clk)
	begin
		sync1_q    <= {cs_n, sck, si, wp_n, hold_n};
		sync2_q    <= sync1_q;
		sck_prev_q <= sync2_q[3];
		cs_prev_q  <= sync2_q[4];
	end

	logic cs_n_s, sck_s, si_s, wp_n_s, hold_n_s;
	assign cs_n_s   = sync2_q[4];
	assign sck_s    = sync2_q[3];
	assign si_s     = sync2_q[2];
	assign wp_n_s   = sync2_q[1];
	assign hold_n_s = sync2_q[0];

	// Edge strobes; suspend freezes the serial clock
	logic sck_rise, sck_fall, cs_fall, cs_rise, active;
	assign active   = !cs_n_s && hold_n_s;
	assign sck_rise = active && sck_s && !sck_prev_q;
	assign sck_fall = active && !sck_s && sck_prev_q;
	assign cs_fall  = !cs_n_s && cs_prev_q;
	assign cs_rise  = cs_n_s && !cs_prev_q;

	// ==========================================
	// Opcode decode, used for the opcode byte
	function automatic eeprom_pkg::opcode_t decode_op(input logic [7:0] b);
		if (b[7:4] != 4'h0)
			decode_op = eeprom_pkg::op_invalid;
		else
			case (b[2:0])
				3'h1: decode_op = eeprom_pkg::op_status_write;
				3'h2: decode_op = eeprom_pkg::op_array_write;
				3'h3: decode_op = eeprom_pkg::op_array_read;
				3'h4: decode_op = eeprom_pkg::op_clear_latch;
				3'h5: decode_op = eeprom_pkg::op_status_read;
				3'h6: decode_op = eeprom_pkg::op_set_latch;
				default: decode_op = eeprom_pkg::op_invalid;
			endcase
	endfunction

	// Protected test, used only at commit
	function automatic logic in_block(input logic [1:0] bp, input logic [6:0] a);
		case (bp)
			2'h1: in_block = a >= `BP1_BASE;
			2'h2: in_block = a >= `BP2_BASE;
			2'h3: in_block = a >= `BP3_BASE;
			default: in_block = 1'b0;
		endcase
	endfunction

	// ==========================================
	// Registered state
	eeprom_pkg::phase_t  phase_q, phase_d;   // Serial phase
	eeprom_pkg::opcode_t op_q, op_d;         // Current instruction
	logic [7:0] shift_q, shift_d;            // Input shifter
	logic [2:0] bitcnt_q, bitcnt_d;          // Bit within byte
	logic [6:0] addr_q, addr_d;              // Array pointer
	logic [7:0] out_q, out_d;                // Output shifter
	logic       so_q, so_d;                  // Serial output level
	logic       oe_q, oe_d;                  // Serial output enable
	logic       load_q, load_d;              // Reload output at next fall
	logic       wel_q, wel_d;                // Write-enable latch
	logic [1:0] bp_q, bp_d;                  // Protect pair
	logic [1:0] bp_new_q, bp_new_d;          // Pending protect pair
	logic       pend_sr_q, pend_sr_d;        // Status write pending
	logic [7:0] pg_data_q [0:7];             // Page buffer
	logic [7:0] pg_data_d [0:7];
	logic [7:0] pg_valid_q, pg_valid_d;      // Page byte loaded
	logic [3:0] pg_base_q, pg_base_d;        // Page number
	logic       busy_q, busy_d;              // Write cycle running
	logic [31:0] tmr_q, tmr_d;               // Write cycle counter
	logic [2:0] commit_q, commit_d;          // Page slot being written
	logic       committing_q, committing_d;  // Array copy in progress
	logic       bp_init_q = 1'b0;            // Protect pair loaded once, clear only at power-on

	// Array ports
	logic       mem_we;
	logic [6:0] mem_wa;
	logic [7:0] mem_rd;
	logic [6:0] rd_addr;

	// Array read pointer follows the address being serviced
	assign rd_addr = addr_q;

	eeprom_array u_array
	(
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (pg_data_q[commit_q]),
		.rd_addr (rd_addr),
		.rd_data (mem_rd)
	);

	// Commit page slot to the array if loaded
	// protected bytes skipped
	assign mem_we = committing_q && pg_valid_q[commit_q] && !in_block(bp_q, mem_wa);
	assign mem_wa = {pg_base_q, commit_q};

	// ==========================================
	// Next-state logic of the serial engine and write cycle
	always_comb
	begin
		logic [7:0] nb;
		logic       byte_done;
		nb           = {shift_q[6:0], si_s};
		byte_done    = (bitcnt_q == 3'h7);
		phase_d      = phase_q;
		op_d         = op_q;
		shift_d      = shift_q;
		bitcnt_d     = bitcnt_q;
		addr_d       = addr_q;
		out_d        = out_q;
		so_d         = so_q;
		oe_d         = oe_q;
		load_d       = load_q;
		wel_d        = wel_q;
		bp_d         = bp_q;
		bp_new_d     = bp_new_q;
		pend_sr_d    = pend_sr_q;
		pg_data_d    = pg_data_q;
		pg_valid_d   = pg_valid_q;
		pg_base_d    = pg_base_q;
		busy_d       = busy_q;
		tmr_d        = tmr_q;
		commit_d     = commit_q;
		committing_d = committing_q;

		if (cs_fall)
		begin
			phase_d    = eeprom_pkg::ph_opcode;
			bitcnt_d   = 3'h0;
			oe_d       = 1'b0;
			// A status poll while busy keeps the pending write intact
			if (!busy_q)
			begin
				pg_valid_d = 8'h00;
				pend_sr_d  = 1'b0;
			end
		end
		else if (sck_rise && phase_q != eeprom_pkg::ph_idle)
		begin
			shift_d  = nb;
			bitcnt_d = bitcnt_q + 3'h1;
			if (byte_done)
			begin
				unique case (phase_q)
					eeprom_pkg::ph_opcode:
					begin
						op_d    = decode_op(nb);
						phase_d = eeprom_pkg::ph_idle;
						if (busy_q && decode_op(nb) != eeprom_pkg::op_status_read)
							op_d = eeprom_pkg::op_invalid;
						else
							unique case (decode_op(nb))
								eeprom_pkg::op_set_latch:   wel_d = wp_n_s;
								eeprom_pkg::op_clear_latch: wel_d = 1'b0;
								eeprom_pkg::op_status_write: phase_d = eeprom_pkg::ph_data_in;
								eeprom_pkg::op_array_write,
								eeprom_pkg::op_array_read:  phase_d = eeprom_pkg::ph_address;
								eeprom_pkg::op_status_read:
								begin
									phase_d = eeprom_pkg::ph_out;
									load_d  = 1'b1;
								end
								default: phase_d = eeprom_pkg::ph_idle;
							endcase
					end
					eeprom_pkg::ph_address:
					begin
						addr_d    = nb[6:0];
						pg_base_d = nb[6:3];
						if (op_q == eeprom_pkg::op_array_read)
						begin
							phase_d = eeprom_pkg::ph_out;
							load_d  = 1'b1;
						end
						else
							phase_d = eeprom_pkg::ph_data_in;
					end
					eeprom_pkg::ph_data_in:
					begin
						if (op_q == eeprom_pkg::op_status_write)
						begin
							bp_new_d  = nb[`STAT_BP_HI_BIT:`STAT_BP_LO_BIT];
							pend_sr_d = 1'b1;
							phase_d   = eeprom_pkg::ph_idle;
						end
						else
						begin
							pg_data_d[addr_q[2:0]]  = nb;
							pg_valid_d[addr_q[2:0]] = 1'b1;
							addr_d = {pg_base_q, addr_q[2:0] + 3'h1};
						end
					end
					default: phase_d = phase_q;
				endcase
			end
		end
		else if (sck_fall && phase_q == eeprom_pkg::ph_out)
		begin
			oe_d = 1'b1;
			if (load_q)
			begin
				out_d  = (op_q == eeprom_pkg::op_status_read) ?
				         {4'h0, bp_q, wel_q, busy_q} : mem_rd;
				so_d   = out_d[7];
				out_d  = {out_d[6:0], 1'b0};
				load_d = 1'b0;
				if (op_q == eeprom_pkg::op_array_read)
					addr_d = addr_q + 7'h01;
			end
			else
			begin
				so_d  = out_q[7];
				out_d = {out_q[6:0], 1'b0};
			end
			if (bitcnt_q == 3'h7)
				load_d = 1'b1;
		end

		// write cycle begins at select rise
		if (cs_rise)
		begin
			oe_d    = 1'b0;
			phase_d = eeprom_pkg::ph_idle;
			if (wel_q && wp_n_s && !busy_q && bitcnt_q == 3'h0 &&
			    ((op_q == eeprom_pkg::op_array_write && pg_valid_q != 8'h00) ||
			     (op_q == eeprom_pkg::op_status_write && pend_sr_q)))
			begin
				busy_d       = 1'b1;
				tmr_d        = 32'h0;
				commit_d     = 3'h0;
				committing_d = (op_q == eeprom_pkg::op_array_write);
			end
			op_d = eeprom_pkg::op_invalid;
		end

		// Copy page into array one slot per clock
		if (committing_q)
		begin
			commit_d = commit_q + 3'h1;
			if (commit_q == 3'h7)
				committing_d = 1'b0;
		end

		if (busy_q)
		begin
			tmr_d = tmr_q + 32'h1;
			if (tmr_q >= WRITE_CYCLES - 1)
			begin
				busy_d = 1'b0;
				wel_d  = 1'b0;
				if (pend_sr_q)
					bp_d = bp_new_q;
				pend_sr_d = 1'b0;
			end
		end

		if (!wp_n_s)
			wel_d = 1'b0;
	end

	// ==========================================
	// Register update
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_q      <= eeprom_pkg::ph_idle;
			op_q         <= eeprom_pkg::op_invalid;
			shift_q      <= 8'h00;
			bitcnt_q     <= 3'h0;
			addr_q       <= 7'h00;
			out_q        <= 8'h00;
			so_q         <= 1'b0;
			oe_q         <= 1'b0;
			load_q       <= 1'b0;
			wel_q        <= 1'b0;
			bp_new_q     <= 2'h0;
			pend_sr_q    <= 1'b0;
			pg_valid_q   <= 8'h00;
			pg_base_q    <= 4'h0;
			busy_q       <= 1'b0;
			tmr_q        <= 32'h0;
			commit_q     <= 3'h0;
			committing_q <= 1'b0;
		end
		else
		begin
			phase_q      <= phase_d;
			op_q         <= op_d;
			shift_q      <= shift_d;
			bitcnt_q     <= bitcnt_d;
			addr_q       <= addr_d;
			out_q        <= out_d;
			so_q         <= so_d;
			oe_q         <= oe_d;
			load_q       <= load_d;
			wel_q        <= wel_d;
			bp_new_q     <= bp_new_d;
			pend_sr_q    <= pend_sr_d;
			pg_valid_q   <= pg_valid_d;
			pg_base_q    <= pg_base_d;
			busy_q       <= busy_d;
			tmr_q        <= tmr_d;
			commit_q     <= commit_d;
			committing_q <= committing_d;
		end
		pg_data_q <= pg_data_d;
	end

	// ==========================================
	// Protect pair: kept through reset like a persistent cell
	// factory value zero, survives reset
	always_ff @(posedge clk)
	begin
		if (!bp_init_q)
		begin
			bp_q      <= `BP_FACTORY;
			bp_init_q <= 1'b1;
		end
		else
		begin
			bp_q <= bp_d;
		end
	end


	// ==========================================
	// Outputs
	// released while deselected
	assign so_oe   = oe_q && active;
	assign so      = so_q;
	assign busy    = busy_q;
	assign standby = cs_n_s && !busy_q;

endmodule
`default_nettype wire

//--- testbench/spi_eeprom_status_protect_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================
// Port checker
module spi_eeprom_status_protect_asserts
#(
	parameter int unsigned WRITE_CYCLES = 20
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	// Side pins and state
	input wire logic wp_n,
	input wire logic hold_n,
	input wire logic busy,
	input wire logic standby
);
	int unsigned busy_cnt_q; // Cycles of busy so far
	int unsigned busy_cnt_d;
	// Count the busy run
	always_comb
	begin
		busy_cnt_d = busy ? busy_cnt_q + 1 : 0;
	end
	always_ff @(posedge clk)
	begin
		busy_cnt_q <= rst ? 0 : busy_cnt_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_oe_desel; cs_n [*4] |-> !so_oe; endproperty
	a_oe_desel: assert property (p_oe_desel) else $error("output driven while deselected");
	property p_oe_hold; !hold_n [*4] |-> !so_oe; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("output driven while paused");
	property p_so_edge; so_oe && $changed(so) |-> !$past(sck, 2); endproperty
	a_so_edge: assert property (p_so_edge) else $error("output moved after a rising clock");
	property p_oe_rise; $rose(so_oe) |-> !$past(sck, 2); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("output enabled after a rising clock");
	property p_standby; cs_n [*4] ##0 !busy |-> standby; endproperty
	a_standby: assert property (p_standby) else $error("no standby while idle");
	property p_busy_standby; busy |-> !standby; endproperty
	a_busy_standby: assert property (p_busy_standby) else $error("standby while busy");
	property p_busy_len; $fell(busy) |-> busy_cnt_q == WRITE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
	property p_busy_start; $rose(busy) |-> cs_n && $past(cs_n); endproperty
	a_busy_start: assert property (p_busy_start) else $error("write began while selected");
	// Main scenarios reached
	c_read: cover property ($rose(so_oe));
	c_write: cover property ($fell(busy));
	c_hold: cover property (!hold_n && !cs_n);
endmodule
bind spi_eeprom_status_protect spi_eeprom_status_protect_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk
	(.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
	.wp_n(wp_n), .hold_n(hold_n), .busy(busy), .standby(standby));
`default_nettype wire

//--- testbench/spi_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================
// Serial master: frames, bytes, pauses
module spi_master_model
(
	// Clock
	input  wire logic clk,
	// Serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n,
	input  wire logic so,
	input  wire logic so_oe
);
	logic cpol;     // Idle clock level
	logic oe_seen;  // Output enable seen in frame
	logic hold_bad; // Output enable seen in pause
	initial
	begin
		{cs_n, hold_n} = 2'h3;
		{sck, si, cpol, oe_seen, hold_bad} = 5'h00;
	end
	// Watch the output enable
	always @(posedge clk)
		if (!cs_n && so_oe)
			oe_seen <= 1'h1;
	task automatic open_frame();
		@(posedge clk);
		cs_n <= 1'h0;
		oe_seen <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic close_frame();
		@(posedge clk);
		sck <= cpol;
		repeat (4) @(posedge clk);
		si <= ~si;
		cs_n <= 1'h1;
		repeat (8) @(posedge clk);
	endtask
	task automatic xfer(input logic [7:0] tx, input int n, input int hb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			@(posedge clk);
			sck <= 1'h0;
			si <= tx[i];
			repeat (4) @(posedge clk);
			if (i == hb)
			begin
				hold_n <= 1'h0;
				repeat (4) @(posedge clk);
				hold_bad = hold_bad | so_oe;
				repeat (4) @(posedge clk);
				hold_n <= 1'h1;
				repeat (4) @(posedge clk);
			end
			sck <= 1'h1;
			repeat (3) @(posedge clk);
			// A released output reads as the inverse of its last level
			rx[i] = so_oe ? so : ~so;
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_spi_eeprom_status_protect.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_spi_eeprom_status_protect;
	// ====================================
	// Signals
	typedef struct {logic s; logic w; logic [7:0] op; logic [7:0] d; logic [7:0] e;} row_t;
	logic       clk;
	logic       rst;
	logic       wp_n;
	logic       cs_n, sck, si, so, so_oe, hold_n, busy, standby;
	int         fails;
	int         cmp_count;
	logic [7:0] r;
	// Latch first, protect pin, opcode, data, status after
	row_t rows [8] = '{
		'{1'h0, 1'h1, 8'h0E, 8'h00, 8'h02},
		'{1'h0, 1'h1, 8'h0C, 8'h00, 8'h00},
		'{1'h0, 1'h0, 8'h06, 8'h00, 8'h00},
		'{1'h1, 1'h1, 8'h01, 8'hF4, 8'h04},
		'{1'h0, 1'h1, 8'h01, 8'h0C, 8'h04},
		'{1'h1, 1'h0, 8'h01, 8'h0C, 8'h04},
		'{1'h1, 1'h1, 8'h09, 8'h08, 8'h08},
		'{1'h1, 1'h1, 8'h01, 8'h00, 8'h00}};
	initial clk = 1'h0;
	always #25 clk = ~clk;
	spi_eeprom_status_protect #(.WRITE_CYCLES(400)) DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .busy(busy), .standby(standby));
	spi_master_model master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
	// ====================================
	// Tasks
	task automatic stop_test();
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 600 && busy !== 1'h0; i++)
			@(posedge clk);
		`CHK(busy, 1'h0)
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] b, input int n);
		master.open_frame();
		master.xfer(a, 8, -1, r);
		master.xfer(b, n, -1, r);
		master.close_frame();
	endtask
	task automatic stat(input logic [7:0] e);
		frame(8'h05, 8'h00, 8);
		`CHK(r, e)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n, input bit w);
		frame(8'h06, 8'h00, 0);
		master.open_frame();
		master.xfer(8'h02, 8, -1, r);
		master.xfer(a, 8, -1, r);
		for (int i = 0; i < n; i++)
			master.xfer(d[31 - 8 * i -: 8], 8, -1, r);
		master.close_frame();
		if (w)
			wait_idle();
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [7:0] b;
		frame(8'h03, a, 8);
		master.open_frame();
		master.xfer(8'h03, 8, -1, r);
		master.xfer(a, 8, -1, r);
		master.xfer(8'h00, 8, -1, b);
		master.xfer(8'h00, 8, -1, r);
		master.close_frame();
		`CHK({b, r}, e)
	endtask
	task automatic set_bp(input logic [7:0] v);
		frame(8'h06, 8'h00, 0);
		frame(8'h01, v, 8);
		// Poll while busy; the new pair must still land
		frame(8'h05, 8'h00, 8);
		wait_idle();
	endtask
	// ====================================
	// Main sequence
	initial
	begin
		rst = 1'h1;
		wp_n = 1'h1;
		fails = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		`CHK({busy, so_oe, standby}, 3'h1)
		stat(8'h00);
		foreach (rows[i])
		begin
			@(posedge clk);
			wp_n <= rows[i].w;
			if (rows[i].s)
				frame(8'h06, 8'h00, 0);
			frame(rows[i].op, rows[i].d, (rows[i].op[2:0] == 3'h1) ? 8 : 0);
			wait_idle();
			stat(rows[i].e);
		end
		wr(8'h05, 32'h11223344, 4, 1'h1);
		wr(8'h7F, 32'hA5000000, 1, 1'h1);
		rd(8'h05, 16'h1122);
		rd(8'h7F, 16'hA544);
		wr(8'h10, 32'h01000000, 1, 1'h0);
		stat(8'h03);
		frame(8'h04, 8'h00, 0);
		stat(8'h03);
		wait_idle();
		stat(8'h00);
		wr(8'h10, 32'hFF000000, 0, 1'h0);
		frame(8'h02, 8'h10, 8);
		`CHK(busy, 1'h0)
		// Whole data byte then half a byte
		master.open_frame();
		master.xfer(8'h02, 8, -1, r);
		master.xfer(8'h10, 8, -1, r);
		master.xfer(8'h5A, 8, -1, r);
		master.xfer(8'hFF, 4, -1, r);
		master.close_frame();
		`CHK(busy, 1'h0)
		frame(8'h07, 8'h00, 8);
		`CHK(master.oe_seen, 1'h0)
		master.open_frame();
		master.xfer(8'h05, 8, -1, r);
		master.xfer(8'h00, 8, 3, r);
		master.close_frame();
		`CHK({master.hold_bad, r}, 9'h002)
		frame(8'h04, 8'h00, 0);
		master.cpol = 1'h1;
		master.close_frame();
		stat(8'h00);
		master.cpol = 1'h0;
		master.close_frame();
		wr(8'h40, 32'h5C000000, 1, 1'h1);
		set_bp(8'h08);
		wr(8'h40, 32'h77000000, 1, 1'h1);
		wr(8'h3F, 32'h66000000, 1, 1'h1);
		rd(8'h3F, 16'h665C);
		set_bp(8'h0C);
		wr(8'h3F, 32'h22000000, 1, 1'h1);
		rd(8'h3F, 16'h665C);
		// reset clears latch, protect pair survives
		frame(8'h06, 8'h00, 0);
		rst <= 1'h1;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		stat(8'h0C);
		stop_test();
	end
	// Hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
